// ---- tmr_match_regs.v ----
// match, prescale, prescale-match and count readback registers of a
// dual timer, with a small counting engine and an event interrupt.
// assumes an apb master on pclk, mode and interval load from the
// configuration block outside, and edge inputs synchronous to pclk.
//
// The APB slave port is this design's own decision.
`timescale 1ns/100ps
`include "tmr_defs.vh"

module tmr_match_regs (
  input  wire        pclk,         // bus and timer clock
  input  wire        presetn,      // async reset, active low
  input  wire        pce,          // clock enable, freezes state when low
  input  wire        psel,         // apb select
  input  wire        penable,      // apb access phase
  input  wire        pwrite,       // apb direction, high for write
  input  wire [11:0] paddr,        // apb byte address
  input  wire [31:0] pwdata,       // apb write data
  output reg  [31:0] prdata,       // apb read data, registered
  output wire        pready,       // apb ready
  output wire        pslverr,      // apb error on unmapped address
  input  wire        cfg_32bit,    // timers joined as one 32-bit timer
  input  wire [1:0]  a_mode,       // timer a mode code
  input  wire [1:0]  b_mode,       // timer b mode code
  input  wire [15:0] a_interval_load, // timer a interval load value
  input  wire [15:0] b_interval_load, // timer b interval load value
  input  wire [1:0]  run,          // per-timer enable, bit 0 is timer a
  input  wire [1:0]  edge_in,      // per-timer edge event pulse
  output wire [1:0]  pwm_out,      // per-timer pwm output, registered
  output wire [1:0]  match_ev,     // per-timer match event pulse
  output wire [1:0]  timeout_ev,   // per-timer time-out event pulse
  output wire        irq           // level interrupt, masked status
);

  // software-visible state
  reg  [15:0] a_match_lower_q;     // a match low half
  reg  [15:0] a_match_upper_q;     // a match high half, 32-bit only
  reg  [15:0] b_match_lower_q;     // b match value
  reg  [7:0]  a_prescale_q;        // a prescale value
  reg  [7:0]  b_prescale_q;        // b prescale value
  reg  [7:0]  a_pmatch_q;          // a prescale match value
  reg  [7:0]  b_pmatch_q;          // b prescale match value
  reg  [3:0]  stat_q;              // sticky event status
  reg  [3:0]  mask_q;              // event mask, one enables
  reg  [3:0]  stat_d;              // next status

  // per-timer engine state, flattened so the generate can drive slices
  wire [31:0] cnt_all;             // {b counter, a counter}
  wire [31:0] stamp_all;           // {b stamp, a stamp}
  wire [1:0]  step;                // counter advances this cycle
  wire [1:0]  m_ev;                // match events
  wire [1:0]  t_ev;                // time-out events
  wire [1:0]  pwm_q_all;           // pwm levels

  // free-running time base sampled as edge timestamp
  reg  [15:0] tbase_q;             // time base counter

  // bus decode
  wire        setup    = psel & ~penable;             // apb setup phase
  wire        access   = psel & penable;              // apb access phase
  wire        hit_a_m  = (paddr == `TMR_OFF_A_MATCH);
  wire        hit_b_m  = (paddr == `TMR_OFF_B_MATCH);
  wire        hit_a_ps = (paddr == `TMR_OFF_A_PS);
  wire        hit_b_ps = (paddr == `TMR_OFF_B_PS);
  wire        hit_a_pm = (paddr == `TMR_OFF_A_PM);
  wire        hit_b_pm = (paddr == `TMR_OFF_B_PM);
  wire        hit_a_c  = (paddr == `TMR_OFF_A_CNT);
  wire        hit_b_c  = (paddr == `TMR_OFF_B_CNT);
  wire        hit_st   = (paddr == `TMR_OFF_IRQ_STAT);
  wire        hit_mk   = (paddr == `TMR_OFF_IRQ_MASK);
  wire        hit_any  = hit_a_m | hit_b_m | hit_a_ps | hit_b_ps |
                         hit_a_pm | hit_b_pm | hit_a_c | hit_b_c |
                         hit_st | hit_mk;
  wire        wr_en    = pce & access & pwrite & hit_any; // write strobe

  // a frozen block must not complete transfers, so ready follows pce
  assign pready  = pce;
  assign pslverr = access & ~hit_any;

  // per-timer views of the registers for the generate loop
  wire [31:0] match_all = {b_match_lower_q, a_match_lower_q};
  wire [15:0] ps_all    = {b_prescale_q, a_prescale_q};
  wire [15:0] pm_all    = {b_pmatch_q, a_pmatch_q};
  wire [31:0] load_all  = {b_interval_load, a_interval_load};
  wire [3:0]  mode_all  = {b_mode, a_mode};

  // joined 32-bit view for rtc and 32-bit down counting
  wire [31:0] match32  = {a_match_upper_q, a_match_lower_q};
  wire        rtc32    = cfg_32bit & (a_mode == `TMR_MODE_RTC);
  wire [31:0] cnt32_nx = cnt_all + 32'h0000_0001;
  wire        all_zero = (cnt_all == 32'h0000_0000);

  // time base keeps running while the block is clocked
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      tbase_q <= 16'h0000;
    end else if (pce) begin
      tbase_q <= tbase_q + 16'h0001;
    end
  end

  genvar gi;
  generate
    for (gi = 0; gi < 2; gi = gi + 1) begin : g_tmr
      reg  [15:0] cnt_q;           // counter
      reg  [15:0] stamp_q;         // last edge timestamp
      reg  [7:0]  psc_q;           // prescaler down counter
      reg         pwm_q;           // pwm level
      wire [1:0]  md     = mode_all[2*gi+1:2*gi];
      wire [15:0] mval   = match_all[16*gi+15:16*gi];
      wire [15:0] lval   = load_all[16*gi+15:16*gi];
      wire [7:0]  psv    = ps_all[8*gi+7:8*gi];
      wire [7:0]  pmv    = pm_all[8*gi+7:8*gi];
      wire        is_edg = ~cfg_32bit & (md == `TMR_MODE_EDGE);
      wire        is_pwm = ~cfg_32bit & (md == `TMR_MODE_PWM);
      // prescaler only in 16-bit counting modes; edge mode counts edges
      wire        use_ps = ~cfg_32bit & ~is_edg;
      wire        ps_end = (psc_q == 8'h00);
      wire [15:0] cnt_dn = cnt_q - 16'h0001;
      // timer b in 32-bit mode borrows from timer a, or takes its carry in rtc
      wire        chain  = (gi == 1) ? (cnt_all[15:0] == 16'h0000)
                                     : 1'b1;
      wire        carry  = (gi == 1) ? (cnt_all[15:0] == 16'hffff)
                                     : 1'b1;
      wire        stp    = cfg_32bit ?
                           (run[0] & (rtc32 ? carry : chain)) :
                           (is_edg ? (run[gi] & edge_in[gi]) :
                                     (run[gi] & ps_end));

      assign step[gi] = stp;

      // match event; other modes ignore the match value entirely
      if (gi == 0) begin : g_ma
        assign m_ev[gi] = cfg_32bit ?
          (rtc32 & run[0] & (cnt32_nx == match32)) :
          (stp & ((is_edg & (cnt_dn == mval)) |
                  (is_pwm & ({cnt_q, psc_q} ==
                             {mval, pmv}))));
      end else begin : g_mb
        assign m_ev[gi] = ~cfg_32bit &
          (stp & ((is_edg & (cnt_dn == mval)) |
                  (is_pwm & ({cnt_q, psc_q} ==
                             {mval, pmv}))));
      end

      // time-out: reload point of the 16-bit or joined counter
      if (gi == 0) begin : g_ta
        assign t_ev[gi] = cfg_32bit ? (~rtc32 & run[0] & all_zero)
                                    : (stp & (cnt_q == 16'h0000));
      end else begin : g_tb
        assign t_ev[gi] = ~cfg_32bit & stp & (cnt_q == 16'h0000);
      end

      // prescaler: one counter step per full prescale period
      always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
          psc_q <= `TMR_RST_PS;
        end else if (pce) begin
          if (!use_ps || !run[gi] || ps_end) begin
            psc_q <= psv;
          end else begin
            psc_q <= psc_q - 8'h01;
          end
        end
      end

      // counter: up in 32-bit rtc, down with reload otherwise
      always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
          cnt_q <= `TMR_RST_CNT;
        end else if (pce && stp) begin
          if (rtc32) begin
            cnt_q <= cnt32_nx[16*gi+15:16*gi];
          end else if (cfg_32bit) begin
            // joined down count reloads only when both halves are zero
            if (all_zero) begin
              cnt_q <= lval;
            end else if (cnt_q == 16'h0000) begin
              cnt_q <= 16'hffff;
            end else begin
              cnt_q <= cnt_dn;
            end
          end else if (is_edg && cnt_dn == mval) begin
            cnt_q <= lval;
          end else if (cnt_q == 16'h0000) begin
            cnt_q <= lval;
          end else begin
            cnt_q <= cnt_dn;
          end
        end
      end

      // timestamp of the most recent edge in edge-count mode
      always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
          stamp_q <= `TMR_RST_CNT;
        end else if (pce && is_edg && run[gi] && edge_in[gi]) begin
          stamp_q <= tbase_q;
        end
      end

      // pwm high above the match point: load and match set the duty
      always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
          pwm_q <= 1'b0;
        end else if (pce) begin
          pwm_q <= is_pwm & run[gi] &
                   ({cnt_q, psc_q} > {mval, pmv});
        end
      end

      assign cnt_all[16*gi+15:16*gi]   = cnt_q;
      assign stamp_all[16*gi+15:16*gi] = stamp_q;
      assign pwm_q_all[gi]             = pwm_q;
    end
  endgenerate

  assign match_ev   = m_ev;
  assign timeout_ev = t_ev;
  assign pwm_out    = pwm_q_all;

  // count readback per timer: live value, or stamp in edge mode
  wire a_edge_rd = ~cfg_32bit & (a_mode == `TMR_MODE_EDGE);
  wire b_edge_rd = ~cfg_32bit & (b_mode == `TMR_MODE_EDGE);
  wire [15:0] a_cnt_rd = a_edge_rd ? stamp_all[15:0]
                                   : cnt_all[15:0];
  wire [15:0] b_cnt_rd = b_edge_rd ? stamp_all[31:16]
                                   : cnt_all[31:16];

  // read mux, reserved bits read as zero
  reg [31:0] rd_d;                 // read data for the decoded address
  always @* begin
    rd_d = 32'h0000_0000;
    if (hit_a_m) begin
      // upper half hidden in 16-bit mode
      rd_d = {(cfg_32bit ? a_match_upper_q : 16'h0000),
              a_match_lower_q};
    end else if (hit_b_m) begin
      rd_d = {16'h0000, b_match_lower_q};
    end else if (hit_a_ps) begin
      rd_d = {24'h00_0000, a_prescale_q};
    end else if (hit_b_ps) begin
      rd_d = {24'h00_0000, b_prescale_q};
    end else if (hit_a_pm) begin
      rd_d = {24'h00_0000, a_pmatch_q};
    end else if (hit_b_pm) begin
      rd_d = {24'h00_0000, b_pmatch_q};
    end else if (hit_a_c) begin
      rd_d = {(cfg_32bit ? cnt_all[31:16] : 16'h0000),
              a_cnt_rd};
    end else if (hit_b_c) begin
      rd_d = {16'h0000, b_cnt_rd};
    end else if (hit_st) begin
      rd_d = {28'h000_0000, stat_q};
    end else if (hit_mk) begin
      rd_d = {28'h000_0000, mask_q};
    end
  end

  // read data captured in setup so it stands through the access phase
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata <= 32'h0000_0000;
    end else if (pce && setup && !pwrite) begin
      prdata <= rd_d;
    end
  end

  // software registers, written in the access phase
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      a_match_lower_q <= `TMR_RST_MATCH;
      a_match_upper_q <= `TMR_RST_MATCH;
      b_match_lower_q <= `TMR_RST_MATCH;
      a_prescale_q    <= `TMR_RST_PS;
      b_prescale_q    <= `TMR_RST_PS;
      a_pmatch_q      <= `TMR_RST_PS;
      b_pmatch_q      <= `TMR_RST_PS;
      mask_q          <= `TMR_RST_EV;
    end else if (wr_en) begin
      if (hit_a_m) begin
        a_match_lower_q <= pwdata[`TMR_LO_HI:0];
        // upper half only takes writes when the timers are joined
        if (cfg_32bit) begin
          a_match_upper_q <= pwdata[`TMR_UP_HI:`TMR_UP_LO];
        end
      end
      if (hit_b_m) begin
        b_match_lower_q <= pwdata[`TMR_LO_HI:0];
      end
      if (hit_a_ps) begin
        a_prescale_q <= pwdata[`TMR_PS_HI:0];
      end
      if (hit_b_ps) begin
        b_prescale_q <= pwdata[`TMR_PS_HI:0];
      end
      if (hit_a_pm) begin
        a_pmatch_q <= pwdata[`TMR_PS_HI:0];
      end
      if (hit_b_pm) begin
        b_pmatch_q <= pwdata[`TMR_PS_HI:0];
      end
      if (hit_mk) begin
        mask_q <= pwdata[`TMR_EV_W-1:0];
      end
    end
  end

  // sticky status: write one clears, a new event wins over the clear
  always @* begin
    stat_d = stat_q;
    if (wr_en && hit_st) begin
      stat_d = stat_q & ~pwdata[`TMR_EV_W-1:0];
    end
    stat_d[`TMR_EV_A_TIMEOUT] = stat_d[`TMR_EV_A_TIMEOUT] | t_ev[0];
    stat_d[`TMR_EV_A_MATCH]   = stat_d[`TMR_EV_A_MATCH]   | m_ev[0];
    stat_d[`TMR_EV_B_TIMEOUT] = stat_d[`TMR_EV_B_TIMEOUT] | t_ev[1];
    stat_d[`TMR_EV_B_MATCH]   = stat_d[`TMR_EV_B_MATCH]   | m_ev[1];
  end

  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      stat_q <= `TMR_RST_EV;
    end else if (pce) begin
      stat_q <= stat_d;
    end
  end

  assign irq = |(stat_q & mask_q);

endmodule // tmr_match_regs

// ---- tmr_defs.vh ----
// constants for the timer match, prescale and count readback block
// assumes a 32-bit apb slave with byte addresses on paddr[11:0]
`ifndef TMR_DEFS_VH
`define TMR_DEFS_VH

// register byte offsets
`define TMR_OFF_A_MATCH    12'h030
`define TMR_OFF_B_MATCH    12'h034
`define TMR_OFF_A_PS       12'h038
`define TMR_OFF_B_PS       12'h03c
`define TMR_OFF_A_PM       12'h040
`define TMR_OFF_B_PM       12'h044
`define TMR_OFF_A_CNT      12'h048
`define TMR_OFF_B_CNT      12'h04c
`define TMR_OFF_IRQ_STAT   12'h050
`define TMR_OFF_IRQ_MASK   12'h054

// reset values
`define TMR_RST_MATCH      16'hffff
`define TMR_RST_CNT        16'hffff
`define TMR_RST_PS         8'h00
`define TMR_RST_EV         4'h0

// field positions
`define TMR_UP_HI          31
`define TMR_UP_LO          16
`define TMR_LO_HI          15
`define TMR_PS_HI          7

// timer mode codes on a_mode / b_mode
`define TMR_MODE_PERIODIC  2'h0
`define TMR_MODE_RTC       2'h1
`define TMR_MODE_EDGE      2'h2
`define TMR_MODE_PWM       2'h3

// event bits of the status and mask registers
`define TMR_EV_A_TIMEOUT   0
`define TMR_EV_A_MATCH     1
`define TMR_EV_B_TIMEOUT   2
`define TMR_EV_B_MATCH     3
`define TMR_EV_W           4

`endif

// ---- tmr_match_regs_checker.sv ----
// concurrent checks on the ports of the timer match register block
// assumes one clock, pclk, and the async active-low reset presetn
`timescale 1ns/100ps
`include "tmr_defs.vh"
module tmr_match_regs_checker (
  input wire        pclk,      // bus and timer clock
  input wire        presetn,   // async reset, active low
  input wire        pce,       // clock enable
  input wire        psel,      // apb select
  input wire        penable,   // apb access phase
  input wire        pwrite,    // apb direction
  input wire [11:0] paddr,     // apb byte address
  input wire [31:0] prdata,    // apb read data
  input wire        pready,    // apb ready
  input wire        pslverr,   // apb error
  input wire        cfg_32bit, // joined 32-bit timer
  input wire [1:0]  a_mode,    // timer a mode
  input wire [1:0]  b_mode,    // timer b mode
  input wire [1:0]  edge_in,   // edge event pulses
  input wire [1:0]  match_ev   // match event pulses
);
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  // access phase of a read, where the master takes prdata
  wire rd_acc = psel && penable && !pwrite;

  property p_ready; pready == pce; endproperty
  a_ready: assert property (p_ready) else $error("pready not pce");
  property p_a_ev; match_ev[0] |-> a_mode != `TMR_MODE_PERIODIC; endproperty
  a_a_ev: assert property (p_a_ev) else $error("a match in periodic");
  property p_b_ev; match_ev[1] |-> b_mode != `TMR_MODE_PERIODIC; endproperty
  a_b_ev: assert property (p_b_ev) else $error("b match in periodic");
  property p_rtc; match_ev[0] && a_mode == `TMR_MODE_RTC |-> cfg_32bit;
  endproperty
  a_rtc: assert property (p_rtc) else $error("rtc match in 16-bit");
  // a timer a edge-mode match is always caused by an edge in that same cycle
  property p_edge;
    match_ev[0] && a_mode == `TMR_MODE_EDGE && !cfg_32bit |-> edge_in[0];
  endproperty
  a_edge: assert property (p_edge) else $error("edge match no edge");
  property p_a_hi;
    rd_acc && paddr == `TMR_OFF_A_MATCH && !cfg_32bit |-> prdata[31:16] == 0;
  endproperty
  a_a_hi: assert property (p_a_hi) else $error("a match upper set");
  property p_b_res;
    rd_acc && (paddr == `TMR_OFF_B_MATCH || paddr == `TMR_OFF_B_CNT)
      |-> prdata[31:16] == 16'h0000;
  endproperty
  a_b_res: assert property (p_b_res) else $error("b upper set");
  property p_ps_res;
    rd_acc && paddr >= `TMR_OFF_A_PS && paddr <= `TMR_OFF_B_PM
      |-> prdata[31:8] == 24'h000000;
  endproperty
  a_ps_res: assert property (p_ps_res) else $error("ps upper set");
  property p_cnt_hi;
    rd_acc && paddr == `TMR_OFF_A_CNT && !cfg_32bit |-> prdata[31:16] == 0;
  endproperty
  a_cnt_hi: assert property (p_cnt_hi) else $error("a count upper");
  // the timer a count register never raises an error, even for writes
  property p_no_err;
    psel && penable && paddr == `TMR_OFF_A_CNT |-> !pslverr;
  endproperty
  a_no_err: assert property (p_no_err) else $error("count access error");
endmodule // tmr_match_regs_checker

bind tmr_match_regs tmr_match_regs_checker tmr_match_regs_checker_inst (
  .pclk(pclk), .presetn(presetn), .pce(pce), .psel(psel),
  .penable(penable), .pwrite(pwrite), .paddr(paddr), .prdata(prdata),
  .pready(pready), .pslverr(pslverr), .cfg_32bit(cfg_32bit),
  .a_mode(a_mode), .b_mode(b_mode), .edge_in(edge_in), .match_ev(match_ev));

// ---- tmr_match_regs_bench.sv ----
// self-checking bench for the timer match register block
// assumes the bench is the apb master and drives the timer inputs itself
`timescale 1ns/100ps
`include "tmr_defs.vh"
module tmr_match_regs_bench;
  reg         pclk = 1'b0;       // 40 mhz clock
  reg         presetn = 1'b0;    // reset, active low
  reg         pce = 1'b1;        // clock enable
  reg         psel = 1'b0;       // apb select
  reg         penable = 1'b0;    // apb access
  reg         pwrite = 1'b0;     // apb direction
  reg  [11:0] paddr = 12'h000;   // apb address
  reg  [31:0] pwdata = 32'h0;    // apb write data
  reg         cfg_32bit = 1'b0;  // joined timer
  reg  [1:0]  a_mode = 2'h0;     // timer a mode
  reg  [1:0]  b_mode = 2'h0;     // timer b mode
  reg  [15:0] a_load = 16'h0;    // timer a interval load
  reg  [15:0] b_load = 16'h0;    // timer b interval load
  reg  [1:0]  run = 2'h0;        // timer enables
  reg  [1:0]  edge_in = 2'h0;    // edge events
  wire [31:0] prdata;            // read data
  wire        pready;            // ready
  wire        pslverr;           // error
  wire [1:0]  match_ev;          // match pulses
  wire        irq;               // interrupt
  wire [1:0]  pwm_out;           // pwm levels
  wire [1:0]  tmo_ev;            // time-out pulses
  reg  [31:0] rdat;              // last read data
  reg         rerr;              // last error flag
  reg  [31:0] r1;                // earlier count read
  reg  [11:0] ad;                // loop address
  reg  [1:0]  seen;              // first match seen per timer
  integer     n_mismatch = 0;    // mismatches
  integer     n_compared = 0;    // comparisons
  integer     cyc;               // edge loop cycle
  integer     t;                 // timer index
  integer     cnt [0:1];         // cycles since last match
  integer     gap [0:1];         // edges between two matches
  integer     n_hi;              // pwm high cycles in a window
  integer     n_mt;              // match pulses in a window
  integer     n_to;              // time-out pulses in a window
  reg  [15:0] tb_ref;            // reference edge time base

  // free-running clock, 25 ns period
  always #12.5 pclk = ~pclk;

  // reference time base: cleared by reset, one step per enabled cycle
  always @(posedge pclk or negedge presetn) begin
    if (!presetn)
      tb_ref <= 16'h0000;
    else if (pce)
      tb_ref <= tb_ref + 16'h0001;
  end

  // count pwm high cycles, match and time-out pulses of timer a
  task ev_cnt(input integer n, output integer hi, output integer mt,
              output integer to);
    integer i;
    begin
      hi = 0;
      mt = 0;
      to = 0;
      for (i = 0; i < n; i = i + 1) begin
        @(negedge pclk);
        hi = hi + pwm_out[0];
        mt = mt + match_ev[0];
        to = to + tmo_ev[0];
      end
    end
  endtask

  tmr_match_regs tmr_match_regs_inst (
    .pclk(pclk), .presetn(presetn), .pce(pce), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .cfg_32bit(cfg_32bit), .a_mode(a_mode), .b_mode(b_mode),
    .a_interval_load(a_load), .b_interval_load(b_load), .run(run),
    .edge_in(edge_in), .pwm_out(pwm_out), .match_ev(match_ev),
    .timeout_ev(tmo_ev), .irq(irq));

  // verdict and end of run, also reached by a hung wait
  task end_sim;
    begin
      $display("compared %0d mismatched %0d", n_compared, n_mismatch);
      if (n_mismatch == 0 && n_compared > 0)
        $display("Finished cleanly");
      else
        $display("Finished with errors");
      $finish;
    end
  endtask

  // compare one value against its expectation
  task chk(input string nm, input [31:0] seen_v, input [31:0] exp_v);
    begin
      n_compared = n_compared + 1;
      if (seen_v !== exp_v) begin
        n_mismatch = n_mismatch + 1;
        $display("BAD %s exp %h seen %h", nm, exp_v, seen_v);
      end
    end
  endtask

  // one apb transfer; request held until pready is sampled high
  task apb(input w, input [11:0] a, input [31:0] d);
    integer k;
    begin
      @(posedge pclk);
      psel <= 1'b1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1'b1;
      k = 0;
      @(posedge pclk);
      while (pready !== 1'b1 && k < 100) begin
        k = k + 1;
        @(posedge pclk);
      end
      if (k >= 100) begin
        n_mismatch = n_mismatch + 1;
        end_sim;
      end
      rdat = prdata;
      rerr = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
    end
  endtask

  // read a register and compare it
  task rd_chk(input string nm, input [11:0] a, input [31:0] e);
    begin
      apb(1'b0, a, 32'h0);
      chk(nm, rdat, e);
    end
  endtask

  // reset held for two clock edges
  task rst;
    begin
      presetn <= 1'b0;
      repeat (2) @(posedge pclk);
      presetn <= 1'b1;
    end
  endtask

  initial begin
    rst;
    // reset values in 16-bit and 32-bit views
    rd_chk("a_match", `TMR_OFF_A_MATCH, 32'h0000ffff);
    rd_chk("b_match", `TMR_OFF_B_MATCH, 32'h0000ffff);
    for (ad = `TMR_OFF_A_PS; ad <= `TMR_OFF_B_PM; ad = ad + 12'h004)
      rd_chk("prescale", ad, 32'h0);
    rd_chk("a_cnt", `TMR_OFF_A_CNT, 32'h0000ffff);
    rd_chk("b_cnt", `TMR_OFF_B_CNT, 32'h0000ffff);
    cfg_32bit <= 1'b1;
    rd_chk("a_match32", `TMR_OFF_A_MATCH, 32'hffffffff);
    rd_chk("a_cnt32", `TMR_OFF_A_CNT, 32'hffffffff);
    cfg_32bit <= 1'b0;
    $display("test reset values done");
    // writes with reserved bits set, ignored fields, read of an unmapped place
    for (ad = `TMR_OFF_A_PS; ad <= `TMR_OFF_B_PM; ad = ad + 12'h004)
      apb(1'b1, ad, {24'hffffff, ad[7:0]});
    for (ad = `TMR_OFF_A_PS; ad <= `TMR_OFF_B_PM; ad = ad + 12'h004)
      rd_chk("prescale", ad, {24'h0, ad[7:0]});
    apb(1'b1, `TMR_OFF_B_MATCH, 32'hffff1234);
    rd_chk("b_match", `TMR_OFF_B_MATCH, 32'h00001234);
    apb(1'b1, `TMR_OFF_A_MATCH, 32'h5555aaaa);
    rd_chk("a_match", `TMR_OFF_A_MATCH, 32'h0000aaaa);
    rd_chk("b_match", `TMR_OFF_B_MATCH, 32'h00001234);
    cfg_32bit <= 1'b1;
    rd_chk("a_match32", `TMR_OFF_A_MATCH, 32'hffffaaaa);
    cfg_32bit <= 1'b0;
    apb(1'b1, `TMR_OFF_A_CNT, 32'h0);
    rd_chk("a_cnt", `TMR_OFF_A_CNT, 32'h0000ffff);
    apb(1'b0, 12'h100, 32'h0);
    chk("unmapped_err", {31'h0, rerr}, 32'h1);
    chk("unmapped_data", rdat, 32'h0);
    // a second reset in mid-run restores the reset values
    rst;
    rd_chk("a_ps", `TMR_OFF_A_PS, 32'h0);
    rd_chk("b_match", `TMR_OFF_B_MATCH, 32'h0000ffff);
    $display("test register access done");
    // edge count: load 5, match 2 on a and 1 on b, one edge per cycle
    apb(1'b1, `TMR_OFF_A_MATCH, 32'h00000002);
    apb(1'b1, `TMR_OFF_B_MATCH, 32'h00000001);
    a_load <= 16'h0005;
    b_load <= 16'h0005;
    a_mode <= `TMR_MODE_EDGE;
    b_mode <= `TMR_MODE_EDGE;
    run <= 2'b11;
    edge_in <= 2'b11;
    seen = 2'b00;
    for (t = 0; t < 2; t = t + 1) begin
      cnt[t] = 0;
      gap[t] = -1;
    end
    for (cyc = 0; cyc < 70000 && (gap[0] < 0 || gap[1] < 0); cyc = cyc + 1)
    begin
      @(negedge pclk);
      for (t = 0; t < 2; t = t + 1) begin
        cnt[t] = cnt[t] + 1;
        if (match_ev[t] === 1'b1 && gap[t] < 0) begin
          if (seen[t])
            gap[t] = cnt[t];
          seen[t] = 1'b1;
          cnt[t] = 0;
        end
      end
    end
    chk("a_edges", gap[0], 32'd3);
    chk("b_edges", gap[1], 32'd4);
    if (gap[0] < 0 || gap[1] < 0)
      end_sim;
    @(posedge pclk);
    // last edge is taken here; the stamp is the time base before it
    r1 = {16'h0000, tb_ref};
    edge_in <= 2'b00;
    rd_chk("a_stamp", `TMR_OFF_A_CNT, r1);
    repeat (5) @(posedge pclk);
    rd_chk("a_stamp", `TMR_OFF_A_CNT, r1);
    $display("test edge count done");
    // interrupt: sticky status, mask, write-one clear
    run <= 2'b00;
    apb(1'b0, `TMR_OFF_IRQ_STAT, 32'h0);
    chk("status", rdat & 32'ha, 32'ha);
    chk("irq_masked", {31'h0, irq}, 32'h0);
    apb(1'b1, `TMR_OFF_IRQ_MASK, 32'h2);
    @(negedge pclk);
    chk("irq_set", {31'h0, irq}, 32'h1);
    apb(1'b1, `TMR_OFF_IRQ_STAT, 32'h2);
    @(negedge pclk);
    chk("irq_clear", {31'h0, irq}, 32'h0);
    rd_chk("status", `TMR_OFF_IRQ_STAT, 32'h8);
    $display("test interrupt done");
    // periodic mode returns the live, moving count
    a_mode <= `TMR_MODE_PERIODIC;
    run <= 2'b01;
    apb(1'b0, `TMR_OFF_A_CNT, 32'h0);
    r1 = rdat;
    apb(1'b0, `TMR_OFF_A_CNT, 32'h0);
    chk("a_live", {31'h0, r1 !== rdat}, 32'h1);
    $display("test live count done");
    // pwm on timer a: load 5, match 2; 6 states, then 12 with prescale 1
    a_mode <= `TMR_MODE_PWM;
    repeat (14) @(posedge pclk);
    ev_cnt(12, n_hi, n_mt, n_to);
    chk("pwm_high", n_hi, 32'd6);
    chk("pwm_match", n_mt, 32'd2);
    chk("pwm_timeout", n_to, 32'd2);
    apb(1'b1, `TMR_OFF_A_PS, 32'h00000001);
    repeat (14) @(posedge pclk);
    ev_cnt(24, n_hi, n_mt, n_to);
    chk("ps_high", n_hi, 32'd14);
    chk("ps_match", n_mt, 32'd2);
    chk("ps_timeout", n_to, 32'd2);
    $display("test pwm done");
    // rtc: a match needs both halves of the joined up count
    @(posedge pclk);
    run <= 2'b00;
    cfg_32bit <= 1'b1;
    a_mode <= `TMR_MODE_RTC;
    apb(1'b0, `TMR_OFF_A_CNT, 32'h0);
    apb(1'b1, `TMR_OFF_A_MATCH, rdat + 32'h0001_000a);
    run <= 2'b01;
    ev_cnt(20, n_hi, n_mt, n_to);
    chk("rtc_upper", n_mt, 32'd0);
    @(posedge pclk);
    run <= 2'b00;
    apb(1'b0, `TMR_OFF_A_CNT, 32'h0);
    apb(1'b1, `TMR_OFF_A_MATCH, rdat + 32'h0000_000a);
    run <= 2'b01;
    ev_cnt(20, n_hi, n_mt, n_to);
    chk("rtc_lower", n_mt, 32'd1);
    @(posedge pclk);
    run <= 2'b00;
    cfg_32bit <= 1'b0;
    $display("test rtc done");
    end_sim;
  end
endmodule // tmr_match_regs_bench
